// ---- drm_refresh_regs.vh ----
// constants for the refresh scheduling block
`ifndef DRM_REFRESH_REGS_VH
`define DRM_REFRESH_REGS_VH

// clock and printed times
`define DRM_CLK_PERIOD_NS 10
`define DRM_ALL_BANK_REFRESH_CYCLE_TIME_NS 380
`define DRM_PER_BANK_REFRESH_CYCLE_TIME_NS 190
`define DRM_AVERAGE_REFRESH_INTERVAL_NS 3904
// least times round up, the average interval rounds down
`define DRM_ALL_BANK_REFRESH_CYCLE_TIME_CYC ((`DRM_ALL_BANK_REFRESH_CYCLE_TIME_NS + `DRM_CLK_PERIOD_NS - 1) / `DRM_CLK_PERIOD_NS)
`define DRM_PER_BANK_REFRESH_CYCLE_TIME_CYC ((`DRM_PER_BANK_REFRESH_CYCLE_TIME_NS + `DRM_CLK_PERIOD_NS - 1) / `DRM_CLK_PERIOD_NS)
`define DRM_AVERAGE_REFRESH_INTERVAL_CYC (`DRM_AVERAGE_REFRESH_INTERVAL_NS / `DRM_CLK_PERIOD_NS)

// command decode at the first link clock edge, CA[4:0]
`define DRM_CA_REFRESH 5'h08
`define DRM_CA_SR_ENTRY 5'h18
`define DRM_CA_SR_EXIT 5'h14
`define DRM_CA_AB_BIT 5

// refresh rate codes
`define DRM_RATE_LOW_LIMIT 3'h0
`define DRM_RATE_4X 3'h1
`define DRM_RATE_2X 3'h2
`define DRM_RATE_1X 3'h3
`define DRM_RATE_HALF 3'h4
`define DRM_RATE_QUARTER_A 3'h5
`define DRM_RATE_QUARTER_B 3'h6
`define DRM_RATE_HIGH_LIMIT 3'h7

// tally counts in eighths of an all-bank refresh
`define DRM_EIGHTHS_AB 8'sh08
`define DRM_EIGHTHS_PB 8'sh01
`define DRM_TALLY_MAX 8'sh40
`define DRM_TALLY_MIN (-8'sh40)
`define DRM_TALLY_CEIL 8'sh7F

// reset values
`define DRM_BANK_RESET 3'h0
`define DRM_ROW_RESET 16'h0000

`endif

// ---- drm_busy_timer.v ----
// countdown timer holding a busy level for a loaded number of cycles
`timescale 1ns/100ps
module drm_busy_timer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // control
  input wire load,
  input wire [WIDTH-1:0] loadValue,
  // status
  output reg busy
);
  reg [WIDTH-1:0] count;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      count <= {WIDTH{1'b0}};
      busy <= 1'b0;
    end else if (load) begin
      count <= loadValue;
      busy <= 1'b1;
    end else if (count != {WIDTH{1'b0}}) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      busy <= (count != {{(WIDTH-1){1'b0}}, 1'b1});
    end else begin
      busy <= 1'b0;
    end
  end
endmodule

// ---- drm_refresh_sched.v ----
// refresh scheduling logic inside the sdram: bank and row counters, busy banks, tally
// Functional notes
// - refreshing bank refused, other banks stay usable
// - refreshed bank returns idle after cycle
// - all-bank refresh zeroes bank counter
// - all banks idle after all-bank cycle
// - tally frozen during self refresh
// - rate code scales interval, valid 001-110
// - reset and self refresh exit zero counter
// - refresh after all-bank uses incremented row
// - bank address on CA0-CA2 second edge
`timescale 1ns/100ps
`include "drm_refresh_regs.vh"
module drm_refresh_sched #(
  parameter ROW_WIDTH = 16,
  parameter TIMER_WIDTH = 8,
  parameter INTERVAL_WIDTH = 12
) (
  // system clock and reset
  input wire clk_sys,
  input wire resetn,
  // link pins, all asynchronous to clk_sys
  input wire memClk,
  input wire memResetN,
  input wire csPin,
  input wire [5:0] caPin,
  // temperature sensor rate code, asynchronous
  input wire [2:0] sensorRate,
  // counters
  output reg [2:0] bankCounter,
  output reg [ROW_WIDTH-1:0] rowCounter,
  output reg [ROW_WIDTH-1:0] refreshRow,
  // bank state
  output reg [7:0] bankBusy,
  output reg selfRefresh,
  // command strobes
  output reg refreshAbPulse,
  output reg refreshPbPulse,
  output reg [2:0] refreshBank,
  // rate and budget
  output reg [2:0] rateCode,
  output reg rateValid,
  output reg signed [7:0] postponedTally,
  output reg tallyOverLimit
);
  // integer timing figures, cut to the counter widths on purpose below
  localparam [31:0] LIMIT_4X = `DRM_AVERAGE_REFRESH_INTERVAL_CYC * 4;
  localparam [31:0] LIMIT_2X = `DRM_AVERAGE_REFRESH_INTERVAL_CYC * 2;
  localparam [31:0] LIMIT_1X = `DRM_AVERAGE_REFRESH_INTERVAL_CYC;
  localparam [31:0] LIMIT_HALF = `DRM_AVERAGE_REFRESH_INTERVAL_CYC / 2;
  localparam [31:0] LIMIT_QUARTER = `DRM_AVERAGE_REFRESH_INTERVAL_CYC / 4;
  localparam [31:0] PB_CYCLES = `DRM_PER_BANK_REFRESH_CYCLE_TIME_CYC;
  localparam [31:0] AB_CYCLES = `DRM_ALL_BANK_REFRESH_CYCLE_TIME_CYC;
  // two-stage synchronisers; stage one feeds stage two only
  reg clkMeta, clkSync, clkPrev;
  reg rstMeta, rstSync;
  reg csMeta, csSync;
  reg [5:0] caMeta, caSync;
  reg [2:0] rateMeta, rateSync;
  // command decode state
  reg secondEdge;
  reg cmdIsAb;
  reg [7:0] pbLoad;
  reg abLoad;
  reg [INTERVAL_WIDTH-1:0] intervalCount;
  reg [INTERVAL_WIDTH-1:0] intervalLimit;
  reg intervalTick;
  reg signed [7:0] next_tally;
  wire clkRise;
  wire [7:0] pbBusy;
  wire abBusy;
  wire firstRefresh;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      clkMeta <= 1'b0;
      clkSync <= 1'b0;
      clkPrev <= 1'b0;
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
      csMeta <= 1'b0;
      csSync <= 1'b0;
      caMeta <= 6'h00;
      caSync <= 6'h00;
      rateMeta <= 3'h0;
      rateSync <= 3'h0;
    end else begin
      clkMeta <= memClk;
      clkSync <= clkMeta;
      clkPrev <= clkSync;
      rstMeta <= memResetN;
      rstSync <= rstMeta;
      csMeta <= csPin;
      csSync <= csMeta;
      caMeta <= caPin;
      caSync <= caMeta;
      rateMeta <= sensorRate;
      rateSync <= rateMeta;
    end
  end

  // cs and ca share the clock's synchroniser depth, so they line up at the edge
  assign clkRise = clkSync & ~clkPrev;
  assign firstRefresh = clkRise & csSync & ~secondEdge & (caSync[4:0] == `DRM_CA_REFRESH);

  // command sequencer and counters
  always @(posedge clk_sys) begin
    if (!resetn) begin
      secondEdge <= 1'b0;
      cmdIsAb <= 1'b0;
      bankCounter <= `DRM_BANK_RESET;
      rowCounter <= `DRM_ROW_RESET;
      refreshRow <= `DRM_ROW_RESET;
      selfRefresh <= 1'b0;
      refreshAbPulse <= 1'b0;
      refreshPbPulse <= 1'b0;
      refreshBank <= 3'h0;
      pbLoad <= 8'h00;
      abLoad <= 1'b0;
    end else begin
      refreshAbPulse <= 1'b0;
      refreshPbPulse <= 1'b0;
      pbLoad <= 8'h00;
      abLoad <= 1'b0;
      if (!rstSync) begin
        bankCounter <= `DRM_BANK_RESET;
        selfRefresh <= 1'b0;
        secondEdge <= 1'b0;
      end else if (firstRefresh) begin
        secondEdge <= 1'b1;
        cmdIsAb <= caSync[`DRM_CA_AB_BIT];
      end else if (clkRise & secondEdge) begin
        secondEdge <= 1'b0;
        refreshRow <= rowCounter;
        if (cmdIsAb) begin
          refreshAbPulse <= 1'b1;
          abLoad <= 1'b1;
          bankCounter <= `DRM_BANK_RESET;
          rowCounter <= rowCounter + {{(ROW_WIDTH-1){1'b0}}, 1'b1};
        end else begin
          refreshPbPulse <= 1'b1;
          refreshBank <= caSync[2:0];
          pbLoad <= 8'h01 << caSync[2:0];
          bankCounter <= bankCounter + 3'h1;
          if (bankCounter == 3'h7) begin
            rowCounter <= rowCounter + {{(ROW_WIDTH-1){1'b0}}, 1'b1};
          end
        end
      end else if (clkRise & csSync) begin
        if (caSync[4:0] == `DRM_CA_SR_ENTRY) begin
          selfRefresh <= 1'b1;
        end else if (caSync[4:0] == `DRM_CA_SR_EXIT) begin
          selfRefresh <= 1'b0;
          bankCounter <= `DRM_BANK_RESET;
        end
      end
    end
  end

  // per-bank and all-bank busy timers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : pbTimer
      drm_busy_timer #(.WIDTH(TIMER_WIDTH)) uTimer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .load(pbLoad[gi]),
        .loadValue(PB_CYCLES[TIMER_WIDTH-1:0]),
        .busy(pbBusy[gi])
      );
    end
  endgenerate

  drm_busy_timer #(.WIDTH(TIMER_WIDTH)) uAbTimer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(abLoad),
    .loadValue(AB_CYCLES[TIMER_WIDTH-1:0]),
    .busy(abBusy)
  );

  // busy banks refuse access; the rest stay open. expiry leaves banks idle
  always @(posedge clk_sys) begin
    if (!resetn) begin
      bankBusy <= 8'h00;
    end else begin
      bankBusy <= pbBusy | {8{abBusy}};
    end
  end

  // interval length scaled by the rate code
  always @* begin
    case (rateSync)
      `DRM_RATE_4X: intervalLimit = LIMIT_4X[INTERVAL_WIDTH-1:0];
      `DRM_RATE_2X: intervalLimit = LIMIT_2X[INTERVAL_WIDTH-1:0];
      `DRM_RATE_1X: intervalLimit = LIMIT_1X[INTERVAL_WIDTH-1:0];
      `DRM_RATE_HALF: intervalLimit = LIMIT_HALF[INTERVAL_WIDTH-1:0];
      `DRM_RATE_QUARTER_A: intervalLimit = LIMIT_QUARTER[INTERVAL_WIDTH-1:0];
      `DRM_RATE_QUARTER_B: intervalLimit = LIMIT_QUARTER[INTERVAL_WIDTH-1:0];
      default: intervalLimit = {INTERVAL_WIDTH{1'b0}};
    endcase
  end

  // interval timer stops in self refresh and at the limit codes
  always @(posedge clk_sys) begin
    if (!resetn) begin
      intervalCount <= {INTERVAL_WIDTH{1'b0}};
      intervalTick <= 1'b0;
      rateCode <= `DRM_RATE_LOW_LIMIT;
      rateValid <= 1'b0;
    end else begin
      rateCode <= rateSync;
      rateValid <= (rateSync != `DRM_RATE_LOW_LIMIT) && (rateSync != `DRM_RATE_HIGH_LIMIT);
      intervalTick <= 1'b0;
      if (selfRefresh || intervalLimit == {INTERVAL_WIDTH{1'b0}}) begin
        intervalCount <= {INTERVAL_WIDTH{1'b0}};
      end else if (intervalCount + {{(INTERVAL_WIDTH-1){1'b0}}, 1'b1} >= intervalLimit) begin
        intervalCount <= {INTERVAL_WIDTH{1'b0}};
        intervalTick <= 1'b1;
      end else begin
        intervalCount <= intervalCount + {{(INTERVAL_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // tally in eighths: positive is postponed, negative is pulled in
  always @* begin
    next_tally = postponedTally;
    // a tick already in flight when self refresh starts must not land
    if (intervalTick && !selfRefresh && next_tally <= `DRM_TALLY_CEIL - `DRM_EIGHTHS_AB) begin
      next_tally = next_tally + `DRM_EIGHTHS_AB;
    end
    if (refreshAbPulse) begin
      next_tally = next_tally - `DRM_EIGHTHS_AB;
    end else if (refreshPbPulse) begin
      next_tally = next_tally - `DRM_EIGHTHS_PB;
    end
    // pull-ins beyond eight buy nothing later
    if (next_tally < `DRM_TALLY_MIN) begin
      next_tally = `DRM_TALLY_MIN;
    end
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      postponedTally <= 8'sh00;
      tallyOverLimit <= 1'b0;
    end else begin
      postponedTally <= next_tally;
      tallyOverLimit <= (next_tally > `DRM_TALLY_MAX);
    end
  end
endmodule

// ---- drm_refresh_sched_assertions.sv ----
// checker for the refresh scheduling block
`timescale 1ns/100ps
module drm_refresh_sched_assertions #(
  parameter ROW_WIDTH = 16
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // watched outputs
  input wire [2:0] bankCounter,
  input wire [ROW_WIDTH-1:0] rowCounter,
  input wire [7:0] bankBusy,
  input wire selfRefresh,
  input wire refreshAbPulse,
  input wire refreshPbPulse,
  input wire [2:0] refreshBank,
  input wire signed [7:0] postponedTally
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_pulse_single: assert property (refreshPbPulse |=> !refreshPbPulse)
    else $error("pb pulse too long");
  a_ab_zero: assert property (refreshAbPulse |-> bankCounter == 3'h0)
    else $error("ab left bank counter");
  a_pb_advance: assert property (refreshPbPulse |-> bankCounter == $past(bankCounter) + 3'h1)
    else $error("bank counter step");
  a_pb_busy: assert property (refreshPbPulse |-> ##2 bankBusy == (8'h01 << refreshBank))
    else $error("wrong busy bank");
  a_pb_idle: assert property (refreshPbPulse |-> ##21 bankBusy == 8'h00)
    else $error("bank not idle");
  a_ab_busy: assert property (refreshAbPulse |-> ##2 bankBusy == 8'hFF ##38 bankBusy == 8'h00)
    else $error("ab busy span");
  a_tally_frozen: assert property (selfRefresh && $past(selfRefresh) |-> $stable(postponedTally))
    else $error("tally moved in self refresh");
  a_ab_row: assert property (refreshAbPulse |-> rowCounter == $past(rowCounter) + 1'b1)
    else $error("row not advanced");
  c_pb: cover property (refreshPbPulse && refreshBank == 3'h7);
  c_ab: cover property (refreshAbPulse);
  c_self: cover property ($fell(selfRefresh));
endmodule
bind drm_refresh_sched drm_refresh_sched_assertions #(.ROW_WIDTH(ROW_WIDTH)) drm_refresh_sched_assertions_i (
  .clk_sys, .resetn, .bankCounter, .rowCounter, .bankBusy, .selfRefresh,
  .refreshAbPulse, .refreshPbPulse, .refreshBank, .postponedTally);

// ---- drm_ctrl_model.sv ----
// host controller model that sends refresh frames on the link
`timescale 1ns/100ps
module drm_ctrl_model (
  // link pins
  output logic memClk,
  output logic csPin,
  output logic [5:0] caPin
);
  initial begin
    memClk = 1'b0;
    csPin = 1'b0;
    caPin = 6'h3F;
  end
  // link clock stands still between frames; idle pins show the inverse, not a stale value
  task automatic frame(input logic [5:0] first, input logic [5:0] second);
    csPin = 1'b1;
    caPin = first;
    #62.5 memClk = 1'b1;
    #62.5 memClk = 1'b0;
    csPin = 1'b0;
    caPin = second;
    #62.5 memClk = 1'b1;
    #62.5 memClk = 1'b0;
    caPin = ~second;
    // gap covers the longer refresh cycle time before anything else
    #500;
  endtask
  // bank choice is kept by the caller, who only targets idle banks
  task automatic per_bank_refresh_cmd(input logic [2:0] bank);
    frame(6'h08, {3'h0, bank});
  endtask
  task automatic all_bank_refresh_cmd;
    frame(6'h28, 6'h00);
  endtask
endmodule

// ---- drm_refresh_sched_tb.sv ----
// self-checking bench for the refresh scheduling block
`timescale 1ns/100ps
module drm_refresh_sched_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic memResetN = 1'b1;
  logic [2:0] sensorRate = 3'h3;
  wire memClk, csPin, selfRefresh, refreshAbPulse, refreshPbPulse, rateValid, tallyOverLimit;
  wire [5:0] caPin;
  wire [2:0] bankCounter, refreshBank, rateCode;
  wire [15:0] rowCounter, refreshRow;
  wire [7:0] bankBusy;
  wire signed [7:0] postponedTally;
  int failures = 0;
  int n_compared = 0;
  logic [7:0] lastBusy = 8'h00;
  int pbPulses = 0;
  int abPulses = 0;
  // busy pattern and pulse counts are kept so a frame can be judged after it ends
  always @(posedge clk_sys) begin
    if (bankBusy != 8'h00) lastBusy <= bankBusy;
    if (refreshPbPulse) pbPulses <= pbPulses + 1;
    if (refreshAbPulse) abPulses <= abPulses + 1;
  end
  always #5 clk_sys = ~clk_sys;
  drm_ctrl_model drm_ctrl_model_i (.memClk, .csPin, .caPin);
  drm_refresh_sched drm_refresh_sched_i (.clk_sys, .resetn, .memClk, .memResetN, .csPin,
    .caPin, .sensorRate, .bankCounter, .rowCounter, .refreshRow, .bankBusy, .selfRefresh,
    .refreshAbPulse, .refreshPbPulse, .refreshBank, .rateCode, .rateValid,
    .postponedTally, .tallyOverLimit);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // idle from reset: one tally step per interval, margin covers the sync delay
  task automatic t_budget;
    repeat (3140) @(posedge clk_sys);
    check("tally8", postponedTally, 16'h0040);
    check("over8", tallyOverLimit, 16'h0000);
    repeat (390) @(posedge clk_sys);
    check("over9", tallyOverLimit, 16'h0001);
    drm_ctrl_model_i.per_bank_refresh_cmd(3'h0);
    check("tallyPb", postponedTally, 16'h0047);
    drm_ctrl_model_i.all_bank_refresh_cmd;
    check("tallyAb", postponedTally, 16'h003F);
    check("overAb", tallyOverLimit, 16'h0000);
  endtask
  task automatic t_per_bank;
    for (int i = 0; i < 8; i++) begin
      drm_ctrl_model_i.per_bank_refresh_cmd(3'(i));
      check("bank", bankCounter, 16'((i + 1) % 8));
      check("refBank", refreshBank, 16'(i));
      check("row", refreshRow, 16'h0001);
      check("busyBank", lastBusy, 16'(8'h01 << i));
      check("idle", bankBusy, 16'h0000);
      check("pbPulses", pbPulses, 16'(i + 2));
    end
    check("rowWrap", rowCounter, 16'h0002);
    drm_ctrl_model_i.per_bank_refresh_cmd(3'h6);
    drm_ctrl_model_i.per_bank_refresh_cmd(3'h7);
    check("bank2", bankCounter, 16'h0002);
    drm_ctrl_model_i.all_bank_refresh_cmd;
    check("bankAb", bankCounter, 16'h0000);
    check("busyAll", lastBusy, 16'h00FF);
    check("idleAll", bankBusy, 16'h0000);
    check("abPulses", abPulses, 16'h0002);
    drm_ctrl_model_i.per_bank_refresh_cmd(3'h2);
    check("rowAb", refreshRow, 16'h0003);
  endtask
  task automatic t_self;
    logic signed [7:0] held;
    drm_ctrl_model_i.frame(6'h18, 6'h00);
    held = postponedTally;
    check("inSelf", selfRefresh, 16'h0001);
    repeat (900) @(posedge clk_sys);
    check("held", postponedTally, 16'(held));
    drm_ctrl_model_i.frame(6'h14, 6'h00);
    check("exitBank", bankCounter, 16'h0000);
    check("outSelf", selfRefresh, 16'h0000);
  endtask
  task automatic t_mem_reset;
    drm_ctrl_model_i.per_bank_refresh_cmd(3'h0);
    check("preBank", bankCounter, 16'h0001);
    @(posedge clk_sys) memResetN <= 1'b0;
    repeat (5) @(posedge clk_sys);
    memResetN <= 1'b1;
    check("rstBank", bankCounter, 16'h0000);
  endtask
  task automatic t_rate;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys) sensorRate <= 3'(c);
      repeat (5) @(posedge clk_sys);
      check("rate", rateCode, 16'(c));
      check("valid", rateValid, 16'(c != 0 && c != 7));
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t_budget;
    t_per_bank;
    t_self;
    t_mem_reset;
    t_rate;
    test_done;
  end
  // about 5800 cycles are needed; over twice that means a hang
  initial begin
    #150000;
    failures++;
    test_done;
  end
endmodule
